// *** src/omd_pkg.sv ***
package omd_pkg;

    // ***************************************************************
    // measurement and pin carriers
    // ***************************************************************
    typedef struct packed {
        logic [15:0] temperature;
        logic [15:0] supply;
        logic [15:0] bias;
        logic [15:0] tx_power;
        logic [15:0] rx_power;
    } omd_meas_type;

    typedef struct packed {
        logic tx_disable_pin;
        logic tx_fault;
        logic rx_los;
    } omd_pins_type;

    localparam int unsigned NUM_QTY     = 5;
    localparam int unsigned NUM_LIMITS  = 20;
    localparam int unsigned FLAG_W      = 10;
    localparam int unsigned IDX_W       = 10;

    // ***************************************************************
    // diagnostic page register indices (byte address = 4 * index)
    // ***************************************************************
    localparam logic [9:0] IDX_TEMP_HIGH_ALARM_LIMIT     = 10'h000;
    localparam logic [9:0] IDX_TEMP_LOW_ALARM_LIMIT      = 10'h002;
    localparam logic [9:0] IDX_TEMP_HIGH_WARN_LIMIT      = 10'h004;
    localparam logic [9:0] IDX_TEMP_LOW_WARN_LIMIT       = 10'h006;
    localparam logic [9:0] IDX_SUPPLY_HIGH_ALARM_LIMIT   = 10'h008;
    localparam logic [9:0] IDX_SUPPLY_LOW_ALARM_LIMIT    = 10'h00A;
    localparam logic [9:0] IDX_SUPPLY_HIGH_WARN_LIMIT    = 10'h00C;
    localparam logic [9:0] IDX_SUPPLY_LOW_WARN_LIMIT     = 10'h00E;
    localparam logic [9:0] IDX_BIAS_HIGH_ALARM_LIMIT     = 10'h010;
    localparam logic [9:0] IDX_BIAS_LOW_ALARM_LIMIT      = 10'h012;
    localparam logic [9:0] IDX_BIAS_HIGH_WARN_LIMIT      = 10'h014;
    localparam logic [9:0] IDX_BIAS_LOW_WARN_LIMIT       = 10'h016;
    localparam logic [9:0] IDX_TXPOWER_HIGH_ALARM_LIMIT  = 10'h018;
    localparam logic [9:0] IDX_TXPOWER_LOW_ALARM_LIMIT   = 10'h01A;
    localparam logic [9:0] IDX_TXPOWER_HIGH_WARN_LIMIT   = 10'h01C;
    localparam logic [9:0] IDX_TXPOWER_LOW_WARN_LIMIT    = 10'h01E;
    localparam logic [9:0] IDX_RXPOWER_HIGH_ALARM_LIMIT  = 10'h020;
    localparam logic [9:0] IDX_RXPOWER_LOW_ALARM_LIMIT   = 10'h022;
    localparam logic [9:0] IDX_RXPOWER_HIGH_WARN_LIMIT   = 10'h024;
    localparam logic [9:0] IDX_RXPOWER_LOW_WARN_LIMIT    = 10'h026;
    localparam logic [9:0] IDX_LIMIT_END                 = 10'h027;
    localparam logic [9:0] IDX_CAL_FIRST                 = 10'h038;
    localparam logic [9:0] IDX_CAL_LAST                  = 10'h05E;
    localparam logic [9:0] IDX_DIAG_PAGE_CHECKSUM        = 10'h05F;
    localparam logic [9:0] IDX_LIVE_TEMPERATURE          = 10'h060;
    localparam logic [9:0] IDX_LIVE_SUPPLY               = 10'h062;
    localparam logic [9:0] IDX_LIVE_BIAS                 = 10'h064;
    localparam logic [9:0] IDX_LIVE_TX_POWER             = 10'h066;
    localparam logic [9:0] IDX_LIVE_RX_POWER             = 10'h068;
    localparam logic [9:0] IDX_STATUS_AND_SOFT_CONTROL   = 10'h06E;
    localparam logic [9:0] IDX_ALARM_FLAGS_A             = 10'h070;
    localparam logic [9:0] IDX_ALARM_FLAGS_B             = 10'h071;
    localparam logic [9:0] IDX_WARNING_FLAGS_A           = 10'h074;
    localparam logic [9:0] IDX_WARNING_FLAGS_B           = 10'h075;

    // ***************************************************************
    // identification page, byte i at index IDX_ID_BASE + i
    // ***************************************************************
    localparam logic [9:0] IDX_ID_BASE                   = 10'h100;
    localparam logic [7:0] ID_VENDOR_FIRST               = 8'h25;
    localparam logic [7:0] ID_VENDOR_LAST                = 8'h27;
    localparam logic [7:0] ID_WAVE_MSB                   = 8'h3C;
    localparam logic [7:0] ID_WAVE_LSB                   = 8'h3D;
    localparam logic [7:0] ID_CSUM_BASE                  = 8'h3F;
    localparam logic [7:0] ID_SERIAL_FIRST               = 8'h44;
    localparam logic [7:0] ID_SERIAL_LAST                = 8'h53;
    localparam logic [7:0] ID_CSUM_EXT                   = 8'h5F;

    // ***************************************************************
    // status byte fields
    // ***************************************************************
    localparam int unsigned ST_PIN_DISABLE_BIT = 7;
    localparam int unsigned ST_SOFT_DISABLE_BIT = 6;
    localparam int unsigned ST_FAULT_BIT = 2;
    localparam int unsigned ST_LOS_BIT = 1;
    localparam int unsigned ST_NOT_READY_BIT = 0;
    localparam logic        SOFT_DISABLE_RESET = 1'b0;

    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int unsigned CLK_PERIOD_PS    = 4000;
    localparam longint unsigned SOFT_RESP_MS = 100;
    localparam longint unsigned SOFT_RESP_CYC =
        (SOFT_RESP_MS * 64'd1000000000) / CLK_PERIOD_PS;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage : omd_pkg

// *** src/omd_diag_map.sv ***
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module omd_diag_map #(
    parameter logic [319:0] LIMITS        = '0,
    parameter logic [311:0] CAL_CONST     = '0,
    parameter logic [15:0]  WAVELENGTH_NM = 16'h0352,
    // arbitrary vendor identifier
    parameter logic [23:0]  VENDOR_ID     = 24'hA5_5A_3C,
    parameter logic [127:0] SERIAL_ASCII  = 128'h3030_3030_3030_3030_3030_3030_3030_3031
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    input  wire omd_pkg::omd_meas_type meas,
    input  wire logic                  meas_valid,
    input  wire omd_pkg::omd_pins_type pins_async,
    output logic                       tx_off
);

    // ***************************************************************
    // helpers
    // ***************************************************************
    function automatic logic [15:0] limit_of(input int unsigned n);
        limit_of = LIMITS[16*(omd_pkg::NUM_LIMITS-1-n) +: 16];
    endfunction : limit_of

    function automatic logic [15:0] meas_of(input omd_pkg::omd_meas_type m,
                                            input int unsigned q);
        logic [79:0] flat;
        flat = m;
        meas_of = flat[16*(omd_pkg::NUM_QTY-1-q) +: 16];
    endfunction : meas_of

    // temperature is two's complement, the rest unsigned
    function automatic logic above(input logic [15:0] a, input logic [15:0] b,
                                   input logic sgn);
        above = sgn ? ($signed(a) > $signed(b)) : (a > b);
    endfunction : above

    function automatic logic [7:0] diag_sum();
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 40; i++) begin
            s = s + LIMITS[8*(39-i) +: 8];
        end
        for (int i = 0; i < 39; i++) begin
            s = s + CAL_CONST[8*(38-i) +: 8];
        end
        diag_sum = s;
    endfunction : diag_sum

    function automatic logic [7:0] id_base_sum();
        id_base_sum = VENDOR_ID[23:16] + VENDOR_ID[15:8] + VENDOR_ID[7:0]
                    + WAVELENGTH_NM[15:8] + WAVELENGTH_NM[7:0];
    endfunction : id_base_sum

    function automatic logic [7:0] id_ext_sum();
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 16; i++) begin
            s = s + SERIAL_ASCII[8*i +: 8];
        end
        id_ext_sum = s;
    endfunction : id_ext_sum

    localparam logic [7:0] DIAG_CSUM    = diag_sum();
    localparam logic [7:0] ID_CSUM_BASE = id_base_sum();
    localparam logic [7:0] ID_CSUM_EXT  = id_ext_sum();

    // ***************************************************************
    // pin synchronisers
    // ***************************************************************
    omd_pkg::omd_pins_type pins_meta_q;
    omd_pkg::omd_pins_type pins_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_meta_q <= '0;
            pins_q      <= '0;
        end else begin
            pins_meta_q <= pins_async;
            pins_q      <= pins_meta_q;
        end
    end

    // ***************************************************************
    // bus address and data phase
    // ***************************************************************
    logic             addr_ok;
    logic             take;
    logic [9:0]       acc_idx;
    logic             wr_pend_q;
    logic [9:0]       wr_idx_q;
    logic             soft_q;
    logic             soft_d;
    logic             status_wr;
    logic [31:0]      rd_word;
    logic [31:0]      hrdata_q;

    assign take      = hsel & hready & (htrans == omd_pkg::HTRANS_NONSEQ);
    assign addr_ok   = (haddr[31:12] == 20'h00000) & (haddr[1:0] == 2'h0);
    assign acc_idx   = addr_ok ? haddr[11:2] : 10'h3FF;
    assign status_wr = wr_pend_q & (wr_idx_q == omd_pkg::IDX_STATUS_AND_SOFT_CONTROL);
    // only the soft disable bit takes a write; all else is dropped
    assign soft_d    = status_wr ? hwdata[omd_pkg::ST_SOFT_DISABLE_BIT] : soft_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 10'h000;
        end else begin
            wr_pend_q <= take & hwrite;
            wr_idx_q  <= acc_idx;
        end
    end

    // soft command acts two cycles after the write, far inside 100 ms
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            soft_q <= omd_pkg::SOFT_DISABLE_RESET;
            tx_off <= 1'b0;
        end else begin
            soft_q <= soft_d;
            tx_off <= soft_d | pins_q.tx_disable_pin;
        end
    end

    // ***************************************************************
    // threshold compare and flags
    // ***************************************************************
    logic [omd_pkg::FLAG_W-1:0] alarm_d;
    logic [omd_pkg::FLAG_W-1:0] warn_d;
    logic [omd_pkg::FLAG_W-1:0] alarm_q;
    logic [omd_pkg::FLAG_W-1:0] warn_q;

    for (genvar q = 0; q < omd_pkg::NUM_QTY; q++) begin : g_qty
        wire logic [15:0] live = meas_of(meas, q);
        wire logic        sgn  = (q == 0);
        assign alarm_d[9-2*q] = above(live, limit_of(4*q), sgn);
        assign alarm_d[8-2*q] = above(limit_of(4*q+1), live, sgn);
        assign warn_d[9-2*q]  = above(live, limit_of(4*q+2), sgn);
        assign warn_d[8-2*q]  = above(limit_of(4*q+3), live, sgn);
    end

    // flags only mean something once measurements are valid
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm_q <= '0;
            warn_q  <= '0;
        end else begin
            alarm_q <= meas_valid ? alarm_d : '0;
            warn_q  <= meas_valid ? warn_d  : '0;
        end
    end

    // ***************************************************************
    // read decode
    // ***************************************************************
    logic [7:0] status_byte;
    logic [7:0] id_off;
    logic       in_id;

    assign status_byte = {pins_q.tx_disable_pin,
                          soft_d,
                          3'h0,
                          pins_q.tx_fault,
                          pins_q.rx_los,
                          ~meas_valid};
    assign in_id  = (acc_idx[9:8] == omd_pkg::IDX_ID_BASE[9:8]);
    assign id_off = acc_idx[7:0];

    always_comb begin
        rd_word = 32'h0000_0000;
        if (acc_idx <= omd_pkg::IDX_LIMIT_END) begin
            if (!acc_idx[0]) begin
                rd_word[15:0] = limit_of(32'(acc_idx[5:1]));
            end
        end else if (acc_idx >= omd_pkg::IDX_CAL_FIRST && acc_idx <= omd_pkg::IDX_CAL_LAST) begin
            rd_word[7:0] = CAL_CONST[8*(38-32'(acc_idx - omd_pkg::IDX_CAL_FIRST)) +: 8];
        end else if (acc_idx == omd_pkg::IDX_DIAG_PAGE_CHECKSUM) begin
            rd_word[7:0] = DIAG_CSUM;
        end else if (acc_idx >= omd_pkg::IDX_LIVE_TEMPERATURE
                     && acc_idx <= omd_pkg::IDX_LIVE_RX_POWER && !acc_idx[0]) begin
            // units per count fixed by the measurement front end
            rd_word[15:0] = meas_of(meas, 32'(acc_idx[3:1]));
        end else if (acc_idx == omd_pkg::IDX_STATUS_AND_SOFT_CONTROL) begin
            rd_word[7:0] = status_byte;
        end else if (acc_idx == omd_pkg::IDX_ALARM_FLAGS_A) begin
            rd_word[7:0] = alarm_q[9:2];
        end else if (acc_idx == omd_pkg::IDX_ALARM_FLAGS_B) begin
            rd_word[7:0] = {alarm_q[1:0], 6'h00};
        end else if (acc_idx == omd_pkg::IDX_WARNING_FLAGS_A) begin
            rd_word[7:0] = warn_q[9:2];
        end else if (acc_idx == omd_pkg::IDX_WARNING_FLAGS_B) begin
            rd_word[7:0] = {warn_q[1:0], 6'h00};
        end else if (in_id) begin
            if (id_off >= omd_pkg::ID_VENDOR_FIRST && id_off <= omd_pkg::ID_VENDOR_LAST) begin
                rd_word[7:0] = VENDOR_ID[8*(2-32'(id_off - omd_pkg::ID_VENDOR_FIRST)) +: 8];
            end else if (id_off == omd_pkg::ID_WAVE_MSB) begin
                rd_word[7:0] = WAVELENGTH_NM[15:8];
            end else if (id_off == omd_pkg::ID_WAVE_LSB) begin
                rd_word[7:0] = WAVELENGTH_NM[7:0];
            end else if (id_off == omd_pkg::ID_CSUM_BASE) begin
                rd_word[7:0] = ID_CSUM_BASE;
            end else if (id_off >= omd_pkg::ID_SERIAL_FIRST && id_off <= omd_pkg::ID_SERIAL_LAST) begin
                rd_word[7:0] = SERIAL_ASCII[8*(15-32'(id_off - omd_pkg::ID_SERIAL_FIRST)) +: 8];
            end else if (id_off == omd_pkg::ID_CSUM_EXT) begin
                rd_word[7:0] = ID_CSUM_EXT;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else begin
            hrdata_q <= (take & ~hwrite) ? rd_word : 32'h0000_0000;
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

endmodule : omd_diag_map

`default_nettype wire

// *** verif/omd_diag_map_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module omd_diag_map_properties #(
    parameter logic [319:0] LIMITS = '0
) (
    input wire logic                  hclk,
    input wire logic                  hresetn,
    input wire logic                  hsel,
    input wire logic [31:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic [2:0]            hsize,
    input wire logic [31:0]           hwdata,
    input wire logic                  hready,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire logic [31:0]           hrdata,
    input wire omd_pkg::omd_meas_type meas,
    input wire logic                  meas_valid,
    input wire omd_pkg::omd_pins_type pins_async,
    input wire logic                  tx_off
);
    // ****
    // address phase at one register index
    // ****
    sequence s_acc(logic w, logic [9:0] i);
        hsel && hready && htrans == 2'h2 && hwrite == w && haddr == {20'h0, i, 2'h0};
    endsequence
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_live_temp: assert property (s_acc(0, 10'h060) |=>
        hrdata == {16'h0, $past(meas.temperature)}) else $error("live temperature wrong");
    a_live_rx: assert property (s_acc(0, 10'h068) |=>
        hrdata == {16'h0, $past(meas.rx_power)}) else $error("live rx power wrong");
    a_limit_first: assert property (s_acc(0, 10'h000) |=>
        hrdata == {16'h0, LIMITS[319:304]}) else $error("first limit wrong");
    a_status_rsvd: assert property (s_acc(0, 10'h06E) |=>
        hrdata[31:8] == 24'h0 && hrdata[5:3] == 3'h0) else $error("status reserved set");
    a_not_ready: assert property (($stable(meas_valid)[*3] ##0 s_acc(0, 10'h06E)) |=>
        hrdata[0] == !$past(meas_valid)) else $error("ready bit wrong");
    a_pin_mirror: assert property (($stable(pins_async)[*4] ##0 s_acc(0, 10'h06E)) |=>
        hrdata[7] == $past(pins_async.tx_disable_pin) && hrdata[2] == $past(pins_async.tx_fault)
        && hrdata[1] == $past(pins_async.rx_los)) else $error("pin mirror wrong");
    a_pin_txoff: assert property (pins_async.tx_disable_pin[*4] |-> tx_off)
        else $error("pin did not disable");
    a_soft_txoff: assert property (s_acc(1, 10'h06E) ##1 hwdata[6] |-> ##[1:4] tx_off)
        else $error("soft bit did not disable");
    a_flags_off: assert property ((!meas_valid[*3] ##0 s_acc(0, 10'h070)) |=>
        hrdata == 32'h0) else $error("flags set while invalid");
    a_unmapped: assert property ((hsel && hready && htrans == 2'h2 && !hwrite
        && haddr[31:12] != 20'h0) |=> hrdata == 32'h0) else $error("unmapped read not zero");
endmodule : omd_diag_map_properties
bind omd_diag_map omd_diag_map_properties #(.LIMITS(LIMITS)) u_omd_diag_map_properties (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .meas(meas), .meas_valid(meas_valid),
    .pins_async(pins_async), .tx_off(tx_off)
);
`default_nettype wire

// *** verif/omd_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module omd_host_model (
    input wire logic         hclk,
    input wire logic         hready,
    input wire logic [31:0]  hrdata,
    output var logic         hsel,
    output var logic [31:0]  haddr,
    output var logic [1:0]   htrans,
    output var logic         hwrite,
    output var logic [2:0]   hsize,
    output var logic [31:0]  hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // ****
    // single word transfer, soft control written here
    // ****
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hwdata <= ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer
endmodule : omd_host_model
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [319:0] LIM = {5{64'h4000_0100_3000_0200}};
    localparam logic [311:0] CAL = {39{8'h11}};
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, meas_valid, tx_off;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    omd_pkg::omd_meas_type meas;
    omd_pkg::omd_pins_type pins_async;
    int n_fail = 0;
    int comparisons = 0;
    // vendor identifier value is arbitrary
    omd_diag_map #(.LIMITS(LIM), .CAL_CONST(CAL), .VENDOR_ID(24'h5AC31E)) u_omd_diag_map (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .meas(meas),
        .meas_valid(meas_valid), .pins_async(pins_async), .tx_off(tx_off));
    omd_host_model u_omd_host_model (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // ****
    // shared helpers
    // ****
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task rdc(input logic [11:0] i, input logic [31:0] e);
        logic [31:0] d;
        u_omd_host_model.xfer(1'b0, {18'h0, i, 2'h0}, 32'h0, d);
        chk(d, e);
    endtask : rdc
    task wr(input logic [11:0] i, input logic [31:0] v);
        logic [31:0] d;
        u_omd_host_model.xfer(1'b1, {18'h0, i, 2'h0}, v, d);
        chk({30'h0, hreadyout, hresp}, 32'h2);
    endtask : wr
    task stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    // ****
    // scenarios
    // ****
    task t_map;
        logic [7:0]   s;
        logic [31:0]  d;
        logic [631:0] bytes_all;
        s = 8'h0;
        bytes_all = {LIM, CAL};
        rdc(12'h070, 32'h0);
        for (int k = 0; k < 20; k++) begin
            rdc(12'(2 * k), {16'h0, LIM[319 - 16 * k -: 16]});
        end
        for (int k = 0; k < 79; k++) begin
            s = s + bytes_all[8 * k +: 8];
        end
        rdc(12'h05F, {24'h0, s});
        rdc(12'h038, 32'h11);
        wr(12'h000, 32'hFFFF_FFFF);
        rdc(12'h000, 32'h4000);
        wr(12'h06A, 32'hFFFF_FFFF);
        rdc(12'h06A, 32'h0);
        u_omd_host_model.xfer(1'b0, 32'h0001_01B8, 32'h0, d);
        chk(d, 32'h0);
    endtask : t_map
    task t_id;
        rdc(12'h13C, 32'h03);
        rdc(12'h13D, 32'h52);
        rdc(12'h125, 32'h5A);
        rdc(12'h127, 32'h1E);
        rdc(12'h13F, {24'h0, 8'h5A + 8'hC3 + 8'h1E + 8'h03 + 8'h52});
        rdc(12'h144, 32'h30);
        rdc(12'h153, 32'h31);
        rdc(12'h15F, {24'h0, 8'h30 * 8'd15 + 8'h31});
    endtask : t_id
    task t_flag(input omd_pkg::omd_meas_type m, input logic [7:0] aa, ab, wa, wb);
        @(posedge hclk);
        meas <= m;
        rdc(12'h070, {24'h0, aa});
        rdc(12'h071, {24'h0, ab});
        rdc(12'h074, {24'h0, wa});
        rdc(12'h075, {24'h0, wb});
    endtask : t_flag
    task t_live;
        rdc(12'h06E, 32'h01);
        @(posedge hclk);
        meas <= {16'h5000, 16'h0050, 16'h1000, 16'hFFFF, 16'h0001};
        meas_valid <= 1'b1;
        rdc(12'h060, 32'h5000);
        rdc(12'h062, 32'h0050);
        rdc(12'h064, 32'h1000);
        rdc(12'h066, 32'hFFFF);
        rdc(12'h068, 32'h0001);
        rdc(12'h06E, 32'h00);
        t_flag({16'h5000, 16'h0050, 16'h1000, 16'h1000, 16'h5000}, 8'h90, 8'h80, 8'h90, 8'h80);
        t_flag({16'hF000, 16'h3500, 16'h0150, 16'h4001, 16'h0000}, 8'h42, 8'h40, 8'h66, 8'h40);
        t_flag({5{16'h1000}}, 8'h00, 8'h00, 8'h00, 8'h00);
    endtask : t_live
    task t_status;
        wr(12'h06E, 32'h40);
        repeat (2) @(posedge hclk);
        chk({31'h0, tx_off}, 32'h1);
        rdc(12'h06E, 32'h40);
        wr(12'h06E, 32'hBF);
        rdc(12'h06E, 32'h00);
        chk({31'h0, tx_off}, 32'h0);
        @(posedge hclk);
        pins_async <= 3'b111;
        repeat (4) @(posedge hclk);
        rdc(12'h06E, 32'h86);
        chk({31'h0, tx_off}, 32'h1);
        pins_async <= 3'b000;
        repeat (4) @(posedge hclk);
        rdc(12'h06E, 32'h00);
        chk({31'h0, tx_off}, 32'h0);
    endtask : t_status
    initial begin
        hresetn = 1'b0;
        meas = '0;
        meas_valid = 1'b0;
        pins_async = '0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_map;
        t_id;
        t_live;
        t_status;
        stop_test;
    end
    initial begin
        #100000;
        n_fail++;
        stop_test;
    end
endmodule : testbench
`default_nettype wire
